//--- verilog/adcc_control.v
// Converter control: AXI4-Lite registers, clock divider, conversion sequencer and selects.
// Assumes an external converter core that takes start, clock enable and selects.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_map.vh"
// Function
// - Start bit high then low begins conversion
// - Busy set at start, cleared at completion
// - Disabled converter keeps result registers unchanged
// - Alignment bit selects result packing
// - Channel codes 0-11 select inputs, rest float
// - Codes 0000, 0100, 11xx route external channel
// - Other codes pick internal sources
// - Internal source disconnects external channel path
// - Clock divider: none, or 2 to 128
// - Unimplemented bits read back zero
// - Bandgap amplifier input disconnects reference-input pin
// - Reference select; internal choices disconnect pin
// - Gain select drives amplifier gain
// - Converter pins drop functions, pull-high, direction
// - Conversion lasts 16 periods: 4 sample
// - Completion pulses interrupt request flag

module adcc_control (
    input wire aclk,
    input wire aresetn,
    input wire [4:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [4:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [11:0] core_result,
    input wire core_done,
    input wire [11:0] pin_analog_mode,
    output reg core_start,
    output reg core_clk_en,
    output reg core_sampling,
    output reg converter_enable,
    output reg [11:0] ext_channel_onehot,
    output reg [3:0] internal_source,
    output reg [1:0] reference_select,
    output reg ref_pin_connect,
    output reg ref_input_pin_connect,
    output reg gain_amp_enable,
    output reg [1:0] gain_select,
    output reg bandgap_enable,
    output reg conv_irq_pulse,
    output reg [11:0] pin_func_disable,
    output reg [11:0] pin_pullhigh_off,
    output reg [11:0] pin_dir_override
);

    reg [7:0] conversion_control;
    reg [7:0] input_and_clock_select;
    reg [7:0] reference_and_gain_control;
    reg [7:0] bandgap_control;
    reg [7:0] result_high;
    reg [7:0] result_low;
    reg conv_busy_flag;
    reg start_armed;
    reg [6:0] div_count;
    reg [4:0] period_count;
    reg [4:0] aw_addr;
    reg aw_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_held;
    reg [7:0] wr_byte;
    reg [7:0] rd_byte;
    reg rd_hit;
    reg wr_hit;
    reg tick;
    reg [6:0] div_top;
    reg [3:0] src;
    reg ext_path;
    reg start_seq;

    wire do_write = aw_held && w_held && !s_axi_bvalid;

    // Bus write channel capture, either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 5'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ADCC_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Write decode and divider selection
    always @* begin
        wr_byte = w_data[7:0];
        wr_hit = (aw_addr[4:2] <= 3'h3) && (aw_addr[1:0] == 2'h0);
        case (input_and_clock_select[`ADCC_INSEL_DIV_HI:0])
            3'h0: div_top = 7'h00;
            3'h1: div_top = 7'h01;
            3'h2: div_top = 7'h03;
            3'h3: div_top = 7'h07;
            3'h4: div_top = 7'h0f;
            3'h5: div_top = 7'h1f;
            3'h6: div_top = 7'h3f;
            default: div_top = 7'h7f;
        endcase
        tick = (div_count >= div_top);
        src = input_and_clock_select[`ADCC_INSEL_SRC_HI:`ADCC_INSEL_SRC_LO];
        ext_path = (src == 4'h0) || (src == 4'h4) || (src[3:2] == 2'h3);
        start_seq = do_write && w_strb[0] && aw_addr == `ADCC_OFS_CTRL
            && start_armed && !wr_byte[`ADCC_CTRL_START];
    end

    // Register file and conversion sequencer
    always @(posedge aclk) begin
        if (!aresetn) begin
            conversion_control <= `ADCC_RST_REG;
            input_and_clock_select <= `ADCC_RST_REG;
            reference_and_gain_control <= `ADCC_RST_REG;
            bandgap_control <= `ADCC_RST_REG;
            result_high <= `ADCC_RST_REG;
            result_low <= `ADCC_RST_REG;
            conv_busy_flag <= 1'b0;
            start_armed <= 1'b0;
            div_count <= 7'h00;
            period_count <= 5'h00;
            core_start <= 1'b0;
            core_clk_en <= 1'b0;
            core_sampling <= 1'b0;
            conv_irq_pulse <= 1'b0;
        end else begin
            core_start <= 1'b0;
            conv_irq_pulse <= 1'b0;
            div_count <= tick ? 7'h00 : div_count + 7'h01;
            core_clk_en <= tick && conv_busy_flag;
            // Masked writes keep unimplemented bits zero
            if (do_write && w_strb[0]) begin
                case (aw_addr)
                    `ADCC_OFS_CTRL: begin
                        conversion_control <= wr_byte & `ADCC_MASK_CTRL;
                        start_armed <= wr_byte[`ADCC_CTRL_START];
                    end
                    `ADCC_OFS_INSEL: input_and_clock_select <= wr_byte & `ADCC_MASK_INSEL;
                    `ADCC_OFS_REFGAIN: reference_and_gain_control <= wr_byte & `ADCC_MASK_REFGAIN;
                    `ADCC_OFS_BANDGAP: bandgap_control <= wr_byte & `ADCC_MASK_BANDGAP;
                    default: start_armed <= start_armed;
                endcase
            end
            if (start_seq && conversion_control[`ADCC_CTRL_EN] && !conv_busy_flag) begin
                conv_busy_flag <= 1'b1;
                core_start <= 1'b1;
                period_count <= 5'h00;
                core_sampling <= 1'b1;
            end else if (conv_busy_flag && tick) begin
                period_count <= period_count + 5'h01;
                if (period_count + 5'h01 == `ADCC_SAMPLE_PERIODS) begin
                    core_sampling <= 1'b0;
                end
                if (period_count + 5'h01 == `ADCC_TOTAL_PERIODS) begin
                    conv_busy_flag <= 1'b0;
                    conv_irq_pulse <= 1'b1;
                end
            end
            if (!conversion_control[`ADCC_CTRL_EN]) begin
                conv_busy_flag <= 1'b0;
                core_sampling <= 1'b0;
            end
            // Core result load, only while enabled
            if (core_done && conversion_control[`ADCC_CTRL_EN]) begin
                if (conversion_control[`ADCC_CTRL_ALIGN]) begin
                    result_high <= {4'h0, core_result[11:8]};
                    result_low <= core_result[7:0];
                end else begin
                    result_high <= core_result[11:4];
                    result_low <= {core_result[3:0], 4'h0};
                end
            end
        end
    end

    // Read decode
    always @* begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `ADCC_OFS_CTRL: rd_byte = {conversion_control[7], conv_busy_flag,
                conversion_control[5:0]};
            `ADCC_OFS_INSEL: rd_byte = input_and_clock_select;
            `ADCC_OFS_REFGAIN: rd_byte = reference_and_gain_control;
            `ADCC_OFS_BANDGAP: rd_byte = bandgap_control;
            default: begin
                rd_byte = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Bus read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ADCC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                if (s_axi_araddr == `ADCC_OFS_RESULT) begin
                    s_axi_rdata <= {16'h0000, result_high, result_low};
                    s_axi_rresp <= `ADCC_RESP_OKAY;
                end else begin
                    s_axi_rdata <= {24'h000000, rd_byte};
                    s_axi_rresp <= rd_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Analog select outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            converter_enable <= 1'b0;
            ext_channel_onehot <= 12'h000;
            internal_source <= 4'h0;
            reference_select <= 2'h0;
            ref_pin_connect <= 1'b0;
            ref_input_pin_connect <= 1'b0;
            gain_amp_enable <= 1'b0;
            gain_select <= 2'h0;
            bandgap_enable <= 1'b0;
            pin_func_disable <= 12'h000;
            pin_pullhigh_off <= 12'h000;
            pin_dir_override <= 12'h000;
        end else begin
            converter_enable <= conversion_control[`ADCC_CTRL_EN];
            // Channel one-hot, none when internal or out of range
            if (ext_path && conversion_control[3:0] <= `ADCC_LAST_CHANNEL) begin
                ext_channel_onehot <= 12'h001 << conversion_control[3:0];
            end else begin
                ext_channel_onehot <= 12'h000;
            end
            // Internal source code, zero when external
            internal_source <= ext_path ? 4'h0 : src;
            // Reference pin only for code 01
            reference_select <= reference_and_gain_control[3:2];
            ref_pin_connect <= (reference_and_gain_control[3:2] == 2'h1);
            ref_input_pin_connect <= !reference_and_gain_control[`ADCC_RG_AMPIN];
            gain_amp_enable <= reference_and_gain_control[`ADCC_RG_AMPEN];
            gain_select <= reference_and_gain_control[1:0];
            bandgap_enable <= bandgap_control[0];
            pin_func_disable <= pin_analog_mode;
            pin_pullhigh_off <= pin_analog_mode;
            pin_dir_override <= pin_analog_mode;
        end
    end

endmodule // adcc_control
`default_nettype wire

//--- verilog/adcc_map.vh
// Register offsets, field positions, reset values and timing counts for the converter control.
// Assumes inclusion by the converter control design file only.
`ifndef ADCC_MAP_VH
`define ADCC_MAP_VH

// Register byte addresses
`define ADCC_OFS_CTRL 5'h00
`define ADCC_OFS_INSEL 5'h04
`define ADCC_OFS_REFGAIN 5'h08
`define ADCC_OFS_BANDGAP 5'h0c
`define ADCC_OFS_RESULT 5'h10
// Control register fields
`define ADCC_CTRL_START 7
`define ADCC_CTRL_BUSY 6
`define ADCC_CTRL_EN 5
`define ADCC_CTRL_ALIGN 4
// Input select fields
`define ADCC_INSEL_SRC_HI 7
`define ADCC_INSEL_SRC_LO 4
`define ADCC_INSEL_DIV_HI 2
// Reference and gain fields
`define ADCC_RG_AMPEN 7
`define ADCC_RG_AMPIN 4
// Writable masks, unimplemented bits read zero
`define ADCC_MASK_CTRL 8'hbf
`define ADCC_MASK_INSEL 8'hf7
`define ADCC_MASK_REFGAIN 8'h9f
`define ADCC_MASK_BANDGAP 8'h01
// Reset values
`define ADCC_RST_REG 8'h00
// Conversion timing in converter clock periods
`define ADCC_SAMPLE_PERIODS 5'h04
`define ADCC_TOTAL_PERIODS 5'h10
// Last channel code
`define ADCC_LAST_CHANNEL 4'hb
// Bus responses
`define ADCC_RESP_OKAY 2'h0
`define ADCC_RESP_SLVERR 2'h2

`endif

//--- bench/adcc_checker.sv
// Assertion checker on the converter control ports.
// Assumes binding into adcc_control, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module adcc_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic core_start,
    input wire logic core_clk_en,
    input wire logic conv_irq_pulse,
    input wire logic converter_enable,
    input wire logic [11:0] ext_channel_onehot,
    input wire logic [3:0] internal_source,
    input wire logic [1:0] reference_select,
    input wire logic ref_pin_connect,
    input wire logic [11:0] pin_analog_mode,
    input wire logic [11:0] pin_func_disable,
    input wire logic [11:0] pin_pullhigh_off,
    input wire logic [11:0] pin_dir_override
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [4:0] tick_cnt;
    // Ticks since last start
    always @(posedge aclk) begin
        if (!aresetn || core_start) begin
            tick_cnt <= 5'h00;
        end else if (core_clk_en && tick_cnt != 5'h1f) begin
            tick_cnt <= tick_cnt + 5'h01;
        end
    end
    ext_off_a: assert property (internal_source != 4'h0 |-> ext_channel_onehot == 12'h000)
        else $error("external path open with internal source");
    one_chan_a: assert property ($onehot0(ext_channel_onehot))
        else $error("several channels selected");
    ext_code_a: assert property (internal_source != 4'h4 && internal_source[3:2] != 2'h3)
        else $error("external code shown as internal");
    ref_pin_a: assert property (ref_pin_connect == (reference_select == 2'h1))
        else $error("reference pin connection wrong");
    irq_pulse_a: assert property (conv_irq_pulse |=> !conv_irq_pulse)
        else $error("completion pulse too long");
    conv_len_a: assert property (conv_irq_pulse |-> (tick_cnt + {4'h0, core_clk_en}) inside {5'd15, 5'd16})
        else $error("conversion tick count wrong");
    pin_cfg_a: assert property (pin_func_disable == $past(pin_analog_mode) &&
        pin_pullhigh_off == pin_func_disable && pin_dir_override == pin_func_disable)
        else $error("pin override mismatch");
    start_en_a: assert property (core_start |-> converter_enable ##1 !core_start)
        else $error("start while disabled or too long");
    cover property (core_start);
    cover property (conv_irq_pulse);
    cover property (internal_source != 4'h0);
    cover property (ref_pin_connect);
endmodule // adcc_checker
bind adcc_control adcc_checker i_chk (.aclk, .aresetn, .core_start, .core_clk_en,
    .conv_irq_pulse, .converter_enable, .ext_channel_onehot, .internal_source,
    .reference_select, .ref_pin_connect, .pin_analog_mode, .pin_func_disable,
    .pin_pullhigh_off, .pin_dir_override);
`default_nettype wire

//--- bench/adcc_core_model.sv
// Converter core model: counts ticks after start, then strobes a result.
// Assumes one converter tick per core_clk_en pulse.
`timescale 1ns/100ps
`default_nettype none
module adcc_core_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic core_start,
    input wire logic core_clk_en,
    input wire logic [11:0] conv_value,
    output logic [11:0] core_result,
    output logic core_done
);
    logic [4:0] ticks;
    logic run;
    always @(posedge aclk) begin
        core_done <= 1'b0;
        core_result <= ~core_result;
        if (!aresetn) begin
            run <= 1'b0;
            ticks <= 5'h00;
            core_result <= 12'h000;
        end else if (core_start) begin
            run <= 1'b1;
            ticks <= 5'h00;
        end else if (run && core_clk_en) begin
            ticks <= ticks + 5'h01;
            if (ticks == 5'h0f) begin
                run <= 1'b0;
                core_done <= 1'b1;
                core_result <= conv_value;
            end
        end
    end
endmodule // adcc_core_model
`default_nettype wire

//--- bench/adcc_control_tb.sv
// Bench: register access, selects and conversion timing.
// Assumes the core model strobes each result after 16 ticks.
`timescale 1ns/100ps
`default_nettype none
module adcc_control_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, cv;
    logic [3:0] s_axi_wstrb = 4'hf, internal_source;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, reference_select, gain_select;
    logic [11:0] core_result, conv_value = 12'h000, pin_analog_mode = 12'h000, v;
    logic [11:0] ext_channel_onehot, pin_func_disable, pin_pullhigh_off, pin_dir_override;
    logic core_done, core_start, core_clk_en, core_sampling, converter_enable, ref_pin_connect;
    logic ref_input_pin_connect, gain_amp_enable, bandgap_enable, conv_irq_pulse, ext;
    int n_mismatch = 0, total_checks = 0, cyc = 0, t_start = 0, t_irq = 0, c, n_irq = 0;
    adcc_control i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_result, .core_done, .pin_analog_mode,
        .core_start, .core_clk_en, .core_sampling, .converter_enable, .ext_channel_onehot,
        .internal_source, .reference_select, .ref_pin_connect, .ref_input_pin_connect,
        .gain_amp_enable, .gain_select, .bandgap_enable, .conv_irq_pulse, .pin_func_disable,
        .pin_pullhigh_off, .pin_dir_override);
    adcc_core_model i_core (.aclk, .aresetn, .core_start, .core_clk_en, .conv_value,
        .core_result, .core_done);
    always #20 aclk = ~aclk;
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (core_start) t_start <= cyc;
        if (conv_irq_pulse) begin
            t_irq <= cyc;
            n_irq <= n_irq + 1;
        end
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er});
        s_axi_bready <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        chk({s_axi_rvalid, s_axi_rresp}, {1'b1, er});
        chk(s_axi_rdata, exp);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int k = 0; k < 4; k++) rd_chk(5'(k * 4), 32'h0, 2'h0);
        wr(5'h0c, 32'hffffffff, 2'h0);
        rd_chk(5'h0c, 32'h01, 2'h0);
        chk(bandgap_enable, 1'b1);
        wr(5'h08, 32'hffffffff, 2'h0);
        rd_chk(5'h08, 32'h9f, 2'h0);
        wr(5'h04, 32'hffffffff, 2'h0);
        rd_chk(5'h04, 32'hf7, 2'h0);
        wr(5'h00, 32'hffffff5f, 2'h0);
        rd_chk(5'h00, 32'h1f, 2'h0);
        wr(5'h14, 32'h1, 2'h2);
        wr(5'h10, 32'h1, 2'h2);
        rd_chk(5'h1c, 32'h0, 2'h2);
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            wr(5'h08, {24'h0, 3'h4, k[0], k[1:0], k[1:0]}, 2'h0);
            chk({gain_amp_enable, gain_select, reference_select, ref_pin_connect,
                ref_input_pin_connect}, {1'b1, k[1:0], k[1:0], k == 1, !k[0]});
        end
        pin_analog_mode <= 12'ha5c;
        repeat (3) @(posedge aclk);
        chk(pin_func_disable, 12'ha5c);
        chk(pin_dir_override, 12'ha5c);
        chk(pin_pullhigh_off, 12'ha5c);
        $display("test reference done");
        for (int s = 0; s < 16; s++) begin
            c = (s * 3 + 7) & 15;
            ext = (s == 0 || s == 4 || s >= 12);
            wr(5'h00, 32'(c), 2'h0);
            wr(5'h04, 32'(s << 4), 2'h0);
            chk(ext_channel_onehot, (ext && c < 12) ? 12'h1 << c : 12'h0);
            chk(internal_source, ext ? 4'h0 : 4'(s));
        end
        $display("test selects done");
        for (int d = 0; d < 8; d++) begin
            v = 12'h5a3 ^ (12'h111 * d[2:0]);
            conv_value <= v;
            cv = {26'h0, 1'b1, d[0], 4'h0};
            wr(5'h04, 32'(d), 2'h0);
            wr(5'h00, cv, 2'h0);
            wr(5'h00, cv | 32'h80, 2'h0);
            c = n_irq;
            wr(5'h00, cv, 2'h0);
            chk(core_sampling, 1'b1);
            chk(converter_enable, 1'b1);
            rd_chk(5'h00, cv | 32'h40, 2'h0);
            for (int i = 0; i < 3000 && n_irq == c; i++) @(posedge aclk);
            chk((t_irq - t_start + (1 << d) - 1) >> d, 32'd16);
            rd_chk(5'h00, cv, 2'h0);
            chk(core_sampling, 1'b0);
            rd_chk(5'h10, d[0] ? {20'h0, v} : {16'h0, v, 4'h0}, 2'h0);
        end
        $display("test conversion done");
        conv_value <= 12'h0f0;
        wr(5'h00, 32'h90, 2'h0);
        wr(5'h00, 32'h10, 2'h0);
        rd_chk(5'h00, 32'h10, 2'h0);
        rd_chk(5'h10, {20'h0, v}, 2'h0);
        $display("test disable done");
        finish_test;
    end
endmodule // adcc_control_tb
`default_nettype wire
